/* File: hw/sas_sequencer.sv */
// Function
// RQ1: stop sweep when video level reaches 90% of stored peak.
// RQ2: clear peak on restart or no in-band, never while fine select is high.
// RQ3: five commands: restart, coarse select, fine select, step gate, lock.
// RQ4: restart pulse lasts 18 ms and enables noise control while high.
// RQ5: gate low means no stepping; gate high steps the selected DAC.
// RQ6: coarse and fine selects alone choose which DAC steps.
// RQ7: restart on external request, DAC end of range, video loss, image trip.
// RQ8: restart clears both DACs, rescan stage and video comparator stage.
// RQ9: end of restart raises coarse select, coarse sweep from zero.
// RQ10: first video fall sets first-hit flag and restarts, keeping that flag.
// RQ11: restart end after first hit arms rescan, which arms fine stage.
// RQ12: next video fall in rescan raises fine select and drops coarse.
// RQ13: fine switch starts 3 ms settle, gate low, arms sweep stop.
// RQ14: settle end after fine switch raises gate, fine sweep starts.
// RQ15: ratio trip in fine sweep starts 3 ms settle and latches gate low.
// RQ16: lock rises when second settle pulse ends.
// RQ17: video drop after lock launches a restart.
// RQ18: in-band up then down without video trip opens 3 ms image window.
// RQ19: video trip in image window dropping coarse select launches restart.
// RQ20: video comparator honoured only while in-band flag is high.
// RQ21: inputs synchronous, edges detected by clock, pulses timed by counters.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.svh"

module sas_sequencer #(
    parameter int RESTART_CYCLES = `SAS_RESTART_US * `SAS_CLK_MHZ,
    parameter int SETTLE_CYCLES  = `SAS_SETTLE_US * `SAS_CLK_MHZ,
    parameter int IMAGE_CYCLES   = `SAS_IMAGE_US * `SAS_CLK_MHZ
) (
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic [11:0]         paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // converter side
    input  wire sas_pkg::sas_sense_s sense,
    output sas_pkg::sas_cmd_s        cmd
);

    localparam logic [`SAS_CNT_W-1:0] RESTART_N = `SAS_CNT_W'(RESTART_CYCLES);
    localparam logic [`SAS_CNT_W-1:0] SETTLE_N  = `SAS_CNT_W'(SETTLE_CYCLES);
    localparam logic [`SAS_CNT_W-1:0] IMAGE_N   = `SAS_CNT_W'(IMAGE_CYCLES);

    // one-shot counter: load starts a pulse of n cycles
    function automatic logic [`SAS_CNT_W-1:0] next_count(
        input logic                  load,
        input logic [`SAS_CNT_W-1:0] cnt,
        input logic [`SAS_CNT_W-1:0] n
    );
        if (load) begin
            next_count = n;
        end else if (cnt != '0) begin
            next_count = cnt - `SAS_CNT_W'(1);
        end else begin
            next_count = '0;
        end
    endfunction

    function automatic logic ratio_hit(
        input logic [7:0] lvl,
        input logic [7:0] pk
    );
        logic [11:0] lhs;
        logic [11:0] rhs;
        lhs = 12'({4'h0, lvl} * `SAS_RATIO_DEN);
        rhs = 12'({4'h0, pk} * `SAS_RATIO_NUM);
        ratio_hit = (pk != 8'h00) && (lhs >= rhs);
    endfunction

    sas_pkg::sas_state_e     state;
    logic [`SAS_CNT_W-1:0]   restart_cnt;
    logic [`SAS_CNT_W-1:0]   settle_cnt;
    logic [`SAS_CNT_W-1:0]   image_cnt;
    logic                    restart_q;
    logic                    coarse_q;
    logic                    fine_q;
    logic                    gate_q;
    logic                    lock_q;
    logic                    first_hit_flag;
    logic                    rescan_armed;
    logic                    sweep_stop_latch;
    logic                    video_q;
    logic                    in_band_q;
    logic                    trip_seen;
    logic [7:0]              peak;
    logic [7:0]              level;
    logic                    sw_restart;
    logic                    stop_inhibit;

    logic                    video_ok;
    logic                    video_fall;
    logic                    in_band_fall;
    logic                    image_open;
    logic                    restart_end;
    logic                    settle_end;
    logic                    first_hit;
    logic                    image_trip;
    logic                    video_loss;
    logic                    fine_switch;
    logic                    stop_trip;
    logic                    launch;
    logic                    peak_discharge;
    logic                    apb_access;
    logic                    apb_write;
    logic                    addr_ok;

    // the comparator only counts while in-band is present
    assign video_ok = sense.video_level_comparator & sense.in_band; // [RQ20]
    // video_q is held low during restart so a stale level cannot make an edge
    assign video_fall   = video_q & ~video_ok; // [RQ21]
    assign in_band_fall = in_band_q & ~sense.in_band; // [RQ21]
    assign image_open   = image_cnt != '0;
    assign restart_end  = restart_q && (restart_cnt == `SAS_CNT_W'(1));
    assign settle_end   = settle_cnt == `SAS_CNT_W'(1);

    always_comb begin
        first_hit   = 1'b0;
        image_trip  = 1'b0;
        video_loss  = 1'b0;
        fine_switch = 1'b0;
        stop_trip   = 1'b0;
        unique case (state)
            sas_pkg::S_RESTART: begin
            end
            sas_pkg::S_COARSE: begin
                first_hit = video_fall; // [RQ10]
            end
            sas_pkg::S_RESCAN: begin
                // coarse would drop here; inside the window that means an image line
                image_trip  = video_fall & image_open; // [RQ19]
                fine_switch = video_fall & ~image_open; // [RQ12]
            end
            sas_pkg::S_FINE_SETTLE: begin
                // the backward step crosses the line again: a fall here is no loss
            end
            sas_pkg::S_FINE_SWEEP: begin
                video_loss = video_fall;
                stop_trip  = ratio_hit(level, peak) & ~stop_inhibit; // [RQ1]
            end
            sas_pkg::S_STOP_SETTLE: begin
                video_loss = video_fall;
            end
            sas_pkg::S_LOCKED: begin
                video_loss = video_fall; // [RQ17]
            end
        endcase
    end

    assign launch = sense.external_restart_request | sw_restart | sense.coarse_end
                  | sense.fine_end | video_loss | image_trip | first_hit; // [RQ7]

    // restart pulse timing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_cnt <= '0;
            restart_q   <= 1'b0;
        end else begin
            restart_cnt <= next_count(launch, restart_cnt, RESTART_N); // [RQ4] [RQ21]
            restart_q   <= launch || (restart_cnt > `SAS_CNT_W'(1)); // [RQ4]
        end
    end

    // settle pulse timing, shared by the fine switch and the stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= '0;
        end else if (launch) begin
            settle_cnt <= '0;
        end else begin
            settle_cnt <= next_count(fine_switch | stop_trip, settle_cnt, SETTLE_N); // [RQ13] [RQ15]
        end
    end

    // first-hit flag survives only the restart it launched itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_hit_flag <= 1'b0;
        end else if (first_hit) begin
            first_hit_flag <= 1'b1; // [RQ10]
        end else if (launch) begin
            first_hit_flag <= 1'b0;
        end
    end

    // rescan stage, which arms the fine stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rescan_armed <= 1'b0;
        end else if (launch || restart_q && !restart_end) begin
            rescan_armed <= 1'b0; // [RQ8]
        end else if (restart_end) begin
            rescan_armed <= first_hit_flag; // [RQ11]
        end else if (fine_switch) begin
            rescan_armed <= 1'b0;
        end
    end

    // sweep-stop stage: once tripped the gate stays low until restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sweep_stop_latch <= 1'b0;
        end else if (launch) begin
            sweep_stop_latch <= 1'b0;
        end else if (stop_trip) begin
            sweep_stop_latch <= 1'b1; // [RQ15]
        end
    end

    // sequencing and command outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= sas_pkg::S_RESTART;
            coarse_q <= 1'b0;
            fine_q   <= 1'b0;
            gate_q   <= 1'b0;
            lock_q   <= 1'b0;
        end else if (launch) begin
            state    <= sas_pkg::S_RESTART;
            coarse_q <= 1'b0; // [RQ8]
            fine_q   <= 1'b0; // [RQ8]
            gate_q   <= 1'b0;
            lock_q   <= 1'b0;
        end else begin
            unique case (state)
                sas_pkg::S_RESTART: begin
                    if (restart_end) begin
                        state    <= first_hit_flag ? sas_pkg::S_RESCAN : sas_pkg::S_COARSE; // [RQ11]
                        coarse_q <= 1'b1; // [RQ9]
                        gate_q   <= 1'b1; // [RQ5]
                    end
                end
                sas_pkg::S_COARSE: begin
                end
                sas_pkg::S_RESCAN: begin
                    if (fine_switch) begin
                        state    <= sas_pkg::S_FINE_SETTLE;
                        fine_q   <= 1'b1; // [RQ12] [RQ6]
                        coarse_q <= 1'b0; // [RQ12]
                        gate_q   <= 1'b0; // [RQ13]
                    end
                end
                sas_pkg::S_FINE_SETTLE: begin
                    if (settle_end) begin
                        state  <= sas_pkg::S_FINE_SWEEP;
                        gate_q <= 1'b1; // [RQ14]
                    end
                end
                sas_pkg::S_FINE_SWEEP: begin
                    if (stop_trip) begin
                        state  <= sas_pkg::S_STOP_SETTLE;
                        gate_q <= 1'b0; // [RQ15] [RQ5]
                    end
                end
                sas_pkg::S_STOP_SETTLE: begin
                    if (settle_end) begin
                        state  <= sas_pkg::S_LOCKED;
                        lock_q <= 1'b1; // [RQ16]
                    end
                end
                sas_pkg::S_LOCKED: begin
                end
            endcase
        end
    end

    // video comparator stage and in-band edge tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            video_q   <= 1'b0;
            in_band_q <= 1'b0;
        end else begin
            video_q   <= video_ok & ~launch & ~(restart_q & ~restart_end); // [RQ8] [RQ21]
            in_band_q <= sense.in_band;
        end
    end

    // image trap: watch each in-band episode for a video trip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_seen <= 1'b0;
        end else if (!in_band_q) begin
            trip_seen <= video_ok;
        end else if (video_ok) begin
            trip_seen <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            image_cnt <= '0;
        end else if (launch) begin
            image_cnt <= '0;
        end else begin
            image_cnt <= next_count(in_band_fall & ~trip_seen & ~video_ok & coarse_q, image_cnt,
                                    IMAGE_N); // [RQ18]
        end
    end

    // digital peak store
    assign peak_discharge = (restart_q | ~sense.in_band) & ~fine_q; // [RQ2]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 8'h00;
            peak  <= 8'h00;
        end else begin
            level <= sense.video_level;
            if (peak_discharge) begin
                peak <= 8'h00; // [RQ2]
            end else if (level > peak) begin
                peak <= level; // [RQ1]
            end
        end
    end

    // the restart field doubles as the noise-control enable
    assign cmd = '{restart_pulse:   restart_q,
                   coarse_select:   coarse_q,
                   fine_select:     fine_q,
                   step_clock_gate: gate_q,
                   lock:            lock_q}; // [RQ3] [RQ4] [RQ6]

    // apb slave: one wait state so read data comes from a flip-flop
    assign apb_access = psel & penable & pready;
    assign apb_write  = apb_access & pwrite;
    assign addr_ok    = (paddr == `SAS_OFS_CTRL) || (paddr == `SAS_OFS_STATUS)
                     || (paddr == `SAS_OFS_PEAK);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_ok;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                unique case (paddr)
                    `SAS_OFS_CTRL: begin
                        prdata[`SAS_CTRL_STOP_INH] <= stop_inhibit;
                    end
                    `SAS_OFS_STATUS: begin
                        prdata[`SAS_ST_RESTART]    <= restart_q;
                        prdata[`SAS_ST_COARSE]     <= coarse_q;
                        prdata[`SAS_ST_FINE]       <= fine_q;
                        prdata[`SAS_ST_GATE]       <= gate_q;
                        prdata[`SAS_ST_LOCK]       <= lock_q;
                        prdata[`SAS_ST_FIRST_HIT]  <= first_hit_flag;
                        prdata[`SAS_ST_RESCAN]     <= rescan_armed;
                        prdata[`SAS_ST_STOP_LATCH] <= sweep_stop_latch;
                        prdata[`SAS_ST_IMAGE_WIN]  <= image_open;
                        prdata[`SAS_ST_STATE_LSB +: 3] <= state;
                    end
                    `SAS_OFS_PEAK: begin
                        prdata[`SAS_PK_PEAK_LSB +: 8]  <= peak;
                        prdata[`SAS_PK_LEVEL_LSB +: 8] <= level;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // control register; the restart bit is a self-clearing strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {stop_inhibit, sw_restart} <= `SAS_CTRL_RESET;
        end else begin
            sw_restart <= apb_write && (paddr == `SAS_OFS_CTRL) && pwdata[`SAS_CTRL_SW_RESTART];
            if (apb_write && (paddr == `SAS_OFS_CTRL)) begin
                stop_inhibit <= pwdata[`SAS_CTRL_STOP_INH];
            end
        end
    end

endmodule

`default_nettype wire

/* File: pkg/sas_defs.svh */
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

// register byte offsets
`define SAS_OFS_CTRL        12'h000
`define SAS_OFS_STATUS      12'h004
`define SAS_OFS_PEAK        12'h008

// control fields
`define SAS_CTRL_SW_RESTART 0
`define SAS_CTRL_STOP_INH   1
`define SAS_CTRL_RESET      2'h0

// status fields
`define SAS_ST_RESTART      0
`define SAS_ST_COARSE       1
`define SAS_ST_FINE         2
`define SAS_ST_GATE         3
`define SAS_ST_LOCK         4
`define SAS_ST_FIRST_HIT    5
`define SAS_ST_RESCAN       6
`define SAS_ST_STOP_LATCH   7
`define SAS_ST_IMAGE_WIN    8
`define SAS_ST_STATE_LSB    12

// peak register fields
`define SAS_PK_PEAK_LSB     0
`define SAS_PK_LEVEL_LSB    8

// stop-sweep ratio: level * den >= peak * num
`define SAS_RATIO_NUM       12'h009
`define SAS_RATIO_DEN       12'h00a

// timing
`define SAS_CLK_MHZ         25
`define SAS_RESTART_US      18000
`define SAS_SETTLE_US       3000
`define SAS_IMAGE_US        3000
`define SAS_CNT_W           19

`endif

/* File: pkg/sas_pkg.sv */
package sas_pkg;

    typedef enum logic [2:0] {
        S_RESTART,
        S_COARSE,
        S_RESCAN,
        S_FINE_SETTLE,
        S_FINE_SWEEP,
        S_STOP_SETTLE,
        S_LOCKED
    } sas_state_e;

    // sensed inputs from the analog side
    typedef struct packed {
        logic       video_level_comparator;
        logic       in_band;
        logic       coarse_end;
        logic       fine_end;
        logic       external_restart_request;
        logic [7:0] video_level;
    } sas_sense_s;

    // sequencer commands
    typedef struct packed {
        logic restart_pulse;
        logic coarse_select;
        logic fine_select;
        logic step_clock_gate;
        logic lock;
    } sas_cmd_s;

endpackage

/* File: tb/sas_sequencer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module sas_checker #(
    parameter int RESTART_CYCLES = 40,
    parameter int SETTLE_CYCLES  = 10,
    parameter int IMAGE_CYCLES   = 10
) (
    // clock and reset
    input wire logic                pclk,
    input wire logic                presetn,
    // apb
    input wire logic [11:0]         paddr,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // converter side
    input wire sas_pkg::sas_sense_s sense,
    input wire sas_pkg::sas_cmd_s   cmd
);
    logic [19:0] rcnt;
    logic [19:0] glow;

    // run lengths are counted, a repetition of this size would not unroll
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcnt <= 20'h0_0000;
        end else begin
            rcnt <= cmd.restart_pulse ? rcnt + 20'h0_0001 : 20'h0_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glow <= 20'h0_0000;
        end else begin
            glow <= cmd.step_clock_gate ? 20'h0_0000 : glow + 20'h0_0001;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_restart_len: assert property ($fell(cmd.restart_pulse) |-> rcnt >= RESTART_CYCLES)
        else $error("restart pulse ended early");
    a_restart_end: assert property ($fell(cmd.restart_pulse) |-> cmd.coarse_select && cmd.step_clock_gate)
        else $error("coarse sweep did not start after restart");
    a_restart_clears: assert property (cmd.restart_pulse |-> !(cmd.coarse_select || cmd.fine_select || cmd.lock))
        else $error("selects or lock high during restart");
    a_launch_cause: assert property (sense.external_restart_request || sense.coarse_end || sense.fine_end |=> cmd.restart_pulse)
        else $error("restart not launched");
    a_select_excl: assert property (!(cmd.coarse_select && cmd.fine_select))
        else $error("both sweep selects high");
    a_fine_entry: assert property ($rose(cmd.fine_select) |-> (!cmd.coarse_select && !cmd.step_clock_gate) [*8])
        else $error("fine switch did not hold gate low");
    a_gate_settle: assert property ($rose(cmd.step_clock_gate) |-> glow >= SETTLE_CYCLES)
        else $error("gate reopened before settle ended");
    a_lock_rise: assert property ($rose(cmd.lock) |-> cmd.fine_select && glow >= SETTLE_CYCLES)
        else $error("lock before settle ended");
    a_lock_hold: assert property (cmd.lock |-> !cmd.step_clock_gate && !cmd.coarse_select)
        else $error("stepping while locked");
    a_video_loss: assert property (cmd.lock && $past(sense.video_level_comparator && sense.in_band)
        && !(sense.video_level_comparator && sense.in_band) |-> ##[1:2] cmd.restart_pulse)
        else $error("video loss after lock did not restart");

    c_lock: cover property ($rose(cmd.lock));
    c_fine: cover property ($rose(cmd.fine_select));
    c_slverr: cover property (pready && pslverr);
endmodule

bind sas_sequencer sas_checker #(
    .RESTART_CYCLES(RESTART_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES), .IMAGE_CYCLES(IMAGE_CYCLES)
) u_sas_checker (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense), .cmd(cmd)
);

`default_nettype wire

/* File: tb/sas_far_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sas_far_model #(
    parameter int DAC_STEPS = 64
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // scenario levels from the bench
    input  wire logic               video_in,
    input  wire logic               band_in,
    input  wire logic               ext_in,
    input  wire logic [7:0]         level_in,
    // sequencer side
    input  wire sas_pkg::sas_cmd_s  cmd,
    output var sas_pkg::sas_sense_s sense
);
    int coarse_pos;
    int fine_pos;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse_pos <= 0;
            fine_pos   <= 0;
        end else if (cmd.restart_pulse) begin
            coarse_pos <= 0;
            fine_pos   <= 0;
        end else if (cmd.step_clock_gate) begin
            if (cmd.coarse_select && coarse_pos < DAC_STEPS) begin
                coarse_pos <= coarse_pos + 1;
            end
            if (cmd.fine_select && fine_pos < DAC_STEPS) begin
                fine_pos <= fine_pos + 1;
            end
        end
    end

    // end flags stay up until a restart homes the dac, as a real range switch would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense <= '0;
        end else begin
            sense.video_level_comparator   <= video_in;
            sense.in_band                  <= band_in;
            sense.coarse_end               <= coarse_pos >= DAC_STEPS;
            sense.fine_end                 <= fine_pos >= DAC_STEPS;
            sense.external_restart_request <= ext_in;
            sense.video_level              <= level_in;
        end
    end
endmodule

`default_nettype wire

/* File: tb/test_sweep_acquisition_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

module test_sweep_acquisition_sequencer;
    logic               pclk;
    logic               presetn;
    logic [11:0]        paddr;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    sas_pkg::sas_sense_s sense;
    sas_pkg::sas_cmd_s  cmd;
    sas_pkg::sas_cmd_s  last_cmd;
    logic               k_video;
    logic               k_band;
    logic               k_ext;
    logic [7:0]         k_level;
    int                 fails;
    int                 samples_checked;
    int                 seed;
    logic [4:0]         exp_cmd[$];
    logic [32:0]        exp_rd[$];
    logic [32:0]        msk_rd[$];

    sas_sequencer #(.RESTART_CYCLES(40), .SETTLE_CYCLES(10), .IMAGE_CYCLES(10)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense), .cmd(cmd)
    );

    sas_far_model #(.DAC_STEPS(64)) far (
        .pclk(pclk), .presetn(presetn), .video_in(k_video), .band_in(k_band), .ext_in(k_ext),
        .level_in(k_level), .cmd(cmd), .sense(sense)
    );

    always #20 pclk = ~pclk;

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        if (exp_cmd.size() != 0 || exp_rd.size() != 0) fails++;
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] m, input logic [32:0] v);
        msk_rd.push_back(m);
        exp_rd.push_back(v);
        apb(1'b0, a, 32'($random(seed)));
    endtask

    task automatic expect_restart();
        exp_cmd.push_back(5'h10);
        exp_cmd.push_back(5'h0a);
    endtask

    task automatic wait_cmd(input logic [4:0] v);
        int n;
        n = 0;
        while (cmd !== v && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        if (cmd !== v) check(cmd, v);
    endtask

    task automatic hit(input logic keep_band, input logic [7:0] lvl);
        @(posedge pclk);
        k_band  <= 1'b1;
        k_video <= 1'b1;
        k_level <= lvl;
        repeat (3) @(posedge pclk);
        k_video <= 1'b0;
        k_band  <= keep_band;
        k_level <= 8'h64;
    endtask

    // every command change must match the oldest note; an unnoted change is a mismatch
    always @(posedge pclk) begin
        if (presetn === 1'b1 && cmd !== last_cmd) begin
            if (exp_cmd.size() == 0) check(cmd, last_cmd);
            else check(cmd, exp_cmd.pop_front());
        end
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            check({pslverr, prdata} & msk_rd.pop_front(), exp_rd.pop_front());
        end
        last_cmd <= cmd;
    end

    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        give_verdict();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {paddr, psel, penable, pwrite, pwdata} = '0;
        {k_video, k_band, k_ext, k_level} = '0;
        last_cmd = '0;
        fails = 0;
        samples_checked = 0;
        seed = 21;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h000, '1, 33'h0_0000_0000);
        rd(12'h00c | 12'($random(seed)), '1, 33'h1_0000_0000);
        rd(12'h004, '1, 33'h0_0000_0000);
        expect_restart();
        @(posedge pclk);
        k_ext <= 1'b1;
        @(posedge pclk);
        k_ext <= 1'b0;
        wait_cmd(5'h0a);
        k_video <= 1'b1;
        k_level <= 8'($random(seed));
        repeat (3) @(posedge pclk);
        k_video <= 1'b0;
        expect_restart();
        wait_cmd(5'h10);
        wait_cmd(5'h0a);
        expect_restart();
        hit(1'b0, 8'($random(seed)));
        wait_cmd(5'h10);
        wait_cmd(5'h0a);
        rd(12'h004, 33'h0_0000_7060, 33'h0_0000_2060);
        // in-band without a video trip opens the image trap
        @(posedge pclk);
        k_band <= 1'b1;
        repeat (2) @(posedge pclk);
        k_band <= 1'b0;
        expect_restart();
        hit(1'b0, 8'($random(seed)));
        wait_cmd(5'h10);
        wait_cmd(5'h0a);
        expect_restart();
        hit(1'b0, 8'($random(seed)));
        wait_cmd(5'h10);
        wait_cmd(5'h0a);
        exp_cmd.push_back(5'h04);
        exp_cmd.push_back(5'h06);
        hit(1'b1, 8'hc8);
        wait_cmd(5'h04);
        k_video <= 1'b1;
        wait_cmd(5'h06);
        k_level <= 8'hb3;
        repeat (6) @(posedge pclk);
        exp_cmd.push_back(5'h04);
        exp_cmd.push_back(5'h05);
        k_level <= 8'hb4;
        wait_cmd(5'h05);
        rd(12'h004, 33'h0_0000_701f, 33'h0_0000_6014);
        rd(12'h008, '1, 33'h0_0000_b4c8);
        expect_restart();
        k_video <= 1'b0;
        wait_cmd(5'h10);
        wait_cmd(5'h0a);
        expect_restart();
        msk_rd.push_back(33'h1_0000_0000);
        exp_rd.push_back(33'h0_0000_0000);
        apb(1'b1, 12'h000, 32'($random(seed)) | 32'h0000_0003);
        wait_cmd(5'h10);
        wait_cmd(5'h0a);
        rd(12'h000, 33'h1_0000_0003, 33'h0_0000_0002);
        repeat (4) @(posedge pclk);
        give_verdict();
    end
endmodule

`default_nettype wire
